// ==== src/ler_pkg.sv ====
// Package of constants for the link error reporting block
package ler_pkg;
	// Error codes
	localparam logic [15:0] ERR_SLV_HW_A    = 16'h012c;
	localparam logic [15:0] ERR_SLV_HW_B    = 16'h012d;
	localparam logic [15:0] ERR_PAR_ID      = 16'h012e;
	localparam logic [15:0] ERR_PAR_VAL     = 16'h012f;
	localparam logic [15:0] ERR_PAR_CORRUPT = 16'h0130;
	localparam logic [15:0] ERR_SLV_STAT    = 16'h0131;
	localparam logic [15:0] ERR_SAME_ID     = 16'h0190;
	localparam logic [15:0] ERR_NO_ID       = 16'h0191;
	localparam logic [15:0] ERR_BACKUP      = 16'h01f4;
	// Slave id forming
	localparam logic [9:0]  IN_ID_OFFSET    = 10'h200;
	localparam logic [7:0]  UNSET_ADDR      = 8'hff;
	// Register byte offsets
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_ERR_CODE    = 8'h08;
	localparam logic [7:0]  REG_ERR_ID      = 8'h0c;
	localparam logic [7:0]  REG_COUNTS      = 8'h10;
	// Control fields
	localparam int          CTRL_CLR_BIT    = 0;
	// Status fields
	localparam int          ST_SHORT        = 0;
	localparam int          ST_VDROP        = 1;
	localparam int          ST_DISC         = 2;
	localparam int          ST_ALARM        = 3;
	localparam int          ST_PERR         = 4;
	localparam int          ST_ERRSUM       = 5;
	localparam int          ST_CLR_REQ      = 6;
	// Responses
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ==== src/ler_clear_detect.sv ====
// Detector of the on-then-off pulse of the error clear request
`timescale 1ns/100ps
module ler_clear_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic req,
	output logic      clear_pulse
);
	logic seen_r;
	logic seen_nxt;

	// Arm on the rising level, fire on its fall
	always_comb begin
		seen_nxt    = req;
		clear_pulse = seen_r && !req;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= seen_nxt;
		end
	end
endmodule // ler_clear_detect

// ==== src/ler_top.sv ====
// Link error reporting block with AXI4-Lite register access
`timescale 1ns/100ps
module ler_top #(
	parameter int CNT_W = 8
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Fault events from the link side, one-cycle pulses
	input  wire logic        ev_slave_hw,
	input  wire logic        ev_slave_hw_alt,
	input  wire logic        ev_par_access,
	input  wire logic [9:0]  ev_par_id,
	input  wire logic [255:0] detected_map,
	input  wire logic        ev_par_range,
	input  wire logic        ev_par_corrupt,
	input  wire logic        ev_slave_status,
	input  wire logic        ev_same_id,
	input  wire logic        ev_slave_addr_valid,
	input  wire logic [7:0]  ev_slave_addr,
	input  wire logic        ev_backup_bad,
	input  wire logic [9:0]  ev_slave_id,
	// Line condition levels
	input  wire logic        line_short_cond,
	input  wire logic        line_overcurrent_cond,
	input  wire logic        line_voltage_drop_cond,
	input  wire logic        line_disconnect_cond,
	input  wire logic        bridge_hw_fault,
	// Status outputs
	output logic             line_short_fault_flag,
	output logic             line_voltage_drop_flag,
	output logic             line_disconnect_flag,
	output logic             slave_alarm_flag,
	output logic             param_error_flag,
	output logic             error_status_flag,
	output logic [15:0]      latest_error_code_word,
	output logic [9:0]       latest_error_id_word
);
	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (CNT_W < 1 || CNT_W > 16) begin : g_chk
		$error("CNT_W must be 1 to 16");
	end

	// ************************************************************
	// Event decode
	// ************************************************************
	logic        error_clear_request;
	logic        clr_pulse;
	logic        unset_hit;
	logic        par_id_bad;
	logic        any_ev;
	logic [15:0] ev_code;
	logic        alarm_ev;

	localparam logic [1:0] IN_ID_OFFSET_HI = ler_pkg::IN_ID_OFFSET[9:8];

	// Id lookup; an undetected id is judged by the detection map
	function automatic logic id_known(input logic [9:0] id, input logic [255:0] map);
		logic ok_form;
		ok_form  = (id[9:8] == 2'b00) || (id[9:8] == IN_ID_OFFSET_HI);
		id_known = ok_form && map[id[7:0]];
	endfunction

	// Priority picks the most severe code when events coincide
	always_comb begin
		unset_hit  = ev_slave_addr_valid && (ev_slave_addr == ler_pkg::UNSET_ADDR);
		par_id_bad = ev_par_access && !id_known(ev_par_id, detected_map);
		any_ev     = 1'b1;
		ev_code    = 16'h0000;
		if (ev_backup_bad) begin
			ev_code = ler_pkg::ERR_BACKUP;
		end else if (ev_same_id) begin
			ev_code = ler_pkg::ERR_SAME_ID;
		end else if (unset_hit) begin
			ev_code = ler_pkg::ERR_NO_ID;
		end else if (ev_slave_hw) begin
			ev_code = ler_pkg::ERR_SLV_HW_A;
		end else if (ev_slave_hw_alt) begin
			ev_code = ler_pkg::ERR_SLV_HW_B;
		end else if (ev_slave_status) begin
			ev_code = ler_pkg::ERR_SLV_STAT;
		end else if (par_id_bad) begin
			ev_code = ler_pkg::ERR_PAR_ID;
		end else if (ev_par_range) begin
			ev_code = ler_pkg::ERR_PAR_VAL;
		end else if (ev_par_corrupt) begin
			ev_code = ler_pkg::ERR_PAR_CORRUPT;
		end else begin
			any_ev = 1'b0;
		end
		alarm_ev = ev_slave_status || ev_same_id || unset_hit;
	end

	ler_clear_detect u_clr (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.req         (error_clear_request),
		.clear_pulse (clr_pulse)
	);

	// ************************************************************
	// Flags, codes and counts
	// ************************************************************
	logic             short_r, short_nxt;
	logic             vdrop_r, vdrop_nxt;
	logic             disc_r, disc_nxt;
	logic             alarm_r, alarm_nxt;
	logic             perr_r, perr_nxt;
	logic [15:0]      code_r, code_nxt;
	logic [9:0]       id_r, id_nxt;
	logic [CNT_W-1:0] nerr_r, nerr_nxt;
	logic [CNT_W-1:0] nalm_r, nalm_nxt;
	logic             short_cause;
	logic             perr_ev;

	// Set wins over clear so a fault in the clear cycle is kept
	always_comb begin
		short_cause = line_short_cond || line_overcurrent_cond;
		perr_ev     = par_id_bad || ev_par_range || ev_par_corrupt;
		short_nxt   = (short_r && !clr_pulse) || short_cause;
		vdrop_nxt   = (vdrop_r && !clr_pulse) || line_voltage_drop_cond;
		disc_nxt    = (disc_r && !clr_pulse) || line_disconnect_cond;
		alarm_nxt   = (alarm_r && !clr_pulse) || alarm_ev;
		perr_nxt    = (perr_r && !clr_pulse) || perr_ev;
		code_nxt    = clr_pulse ? 16'h0000 : code_r;
		id_nxt      = clr_pulse ? 10'h000 : id_r;
		nerr_nxt    = clr_pulse ? '0 : nerr_r;
		nalm_nxt    = clr_pulse ? '0 : nalm_r;
		if (any_ev) begin
			code_nxt = ev_code;
			id_nxt   = ev_slave_id;
			nerr_nxt = (clr_pulse ? '0 : nerr_r) + CNT_W'(1);
		end
		if (alarm_ev) begin
			nalm_nxt = (clr_pulse ? '0 : nalm_r) + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_r <= 1'b0;
			vdrop_r <= 1'b0;
			disc_r  <= 1'b0;
			alarm_r <= 1'b0;
			perr_r  <= 1'b0;
			code_r  <= 16'h0000;
			id_r    <= 10'h000;
			nerr_r  <= '0;
			nalm_r  <= '0;
		end else begin
			short_r <= short_nxt;
			vdrop_r <= vdrop_nxt;
			disc_r  <= disc_nxt;
			alarm_r <= alarm_nxt;
			perr_r  <= perr_nxt;
			code_r  <= code_nxt;
			id_r    <= id_nxt;
			nerr_r  <= nerr_nxt;
			nalm_r  <= nalm_nxt;
		end
	end

	// Summary follows the short, drop and disconnect flags and the bridge fault level
	assign error_status_flag      = short_r || vdrop_r || disc_r || bridge_hw_fault;
	assign line_short_fault_flag  = short_r;
	assign line_voltage_drop_flag = vdrop_r;
	assign line_disconnect_flag   = disc_r;
	assign slave_alarm_flag       = alarm_r;
	assign param_error_flag       = perr_r;
	assign latest_error_code_word = code_r;
	assign latest_error_id_word   = id_r;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic        aw_r, aw_nxt;
	logic        w_r, w_nxt;
	logic [7:0]  awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0]  ws_r, ws_nxt;
	logic        bv_r, bv_nxt;
	logic [1:0]  br_r, br_nxt;
	logic        rv_r, rv_nxt;
	logic [1:0]  rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        clr_r, clr_nxt;

	// Address and data are latched independently, in either order
	always_comb begin
		aw_nxt  = aw_r;
		w_nxt   = w_r;
		awa_nxt = awa_r;
		wd_nxt  = wd_r;
		ws_nxt  = ws_r;
		bv_nxt  = bv_r;
		br_nxt  = br_r;
		clr_nxt = clr_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt  = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt  = 1'b1;
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
		end
		if (aw_r && w_r && !bv_r) begin
			aw_nxt = 1'b0;
			w_nxt  = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = ler_pkg::RESP_OKAY;
			if (awa_r[7:2] == ler_pkg::REG_CTRL[7:2]) begin
				if (ws_r[0]) begin
					clr_nxt = wd_r[ler_pkg::CTRL_CLR_BIT];
				end
			end else begin
				br_nxt = ler_pkg::RESP_SLVERR;
			end
		end
		if (bv_r && s_axi_bready) begin
			bv_nxt = 1'b0;
		end
	end

	assign s_axi_awready       = !aw_r && !bv_r;
	assign s_axi_wready        = !w_r && !bv_r;
	assign s_axi_bvalid        = bv_r;
	assign s_axi_bresp         = br_r;
	assign error_clear_request = clr_r;

	// Read mux; unmapped offsets answer with an error
	always_comb begin
		rv_nxt = rv_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rv_nxt = 1'b1;
			rr_nxt = ler_pkg::RESP_OKAY;
			rd_nxt = 32'h0000_0000;
			case (s_axi_araddr[7:2])
				ler_pkg::REG_CTRL[7:2]: begin
					rd_nxt[ler_pkg::CTRL_CLR_BIT] = clr_r;
				end
				ler_pkg::REG_STATUS[7:2]: begin
					rd_nxt[ler_pkg::ST_SHORT]   = short_r;
					rd_nxt[ler_pkg::ST_VDROP]   = vdrop_r;
					rd_nxt[ler_pkg::ST_DISC]    = disc_r;
					rd_nxt[ler_pkg::ST_ALARM]   = alarm_r;
					rd_nxt[ler_pkg::ST_PERR]    = perr_r;
					rd_nxt[ler_pkg::ST_ERRSUM]  = error_status_flag;
					rd_nxt[ler_pkg::ST_CLR_REQ] = clr_r;
				end
				ler_pkg::REG_ERR_CODE[7:2]: begin
					rd_nxt[15:0] = code_r;
				end
				ler_pkg::REG_ERR_ID[7:2]: begin
					rd_nxt[9:0] = id_r;
				end
				ler_pkg::REG_COUNTS[7:2]: begin
					rd_nxt[CNT_W-1:0]     = nerr_r;
					rd_nxt[16+CNT_W-1:16] = nalm_r;
				end
				default: begin
					rr_nxt = ler_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rv_r && s_axi_rready) begin
			rv_nxt = 1'b0;
		end
	end

	assign s_axi_arready = !rv_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rresp   = rr_r;
	assign s_axi_rdata   = rd_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r  <= 1'b0;
			w_r   <= 1'b0;
			awa_r <= 8'h00;
			wd_r  <= 32'h0000_0000;
			ws_r  <= 4'h0;
			bv_r  <= 1'b0;
			br_r  <= 2'b00;
			rv_r  <= 1'b0;
			rr_r  <= 2'b00;
			rd_r  <= 32'h0000_0000;
			clr_r <= 1'b0;
		end else begin
			aw_r  <= aw_nxt;
			w_r   <= w_nxt;
			awa_r <= awa_nxt;
			wd_r  <= wd_nxt;
			ws_r  <= ws_nxt;
			bv_r  <= bv_nxt;
			br_r  <= br_nxt;
			rv_r  <= rv_nxt;
			rr_r  <= rr_nxt;
			rd_r  <= rd_nxt;
			clr_r <= clr_nxt;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_clear_on_off;
		clr_r ##1 !clr_r;
	endsequence

	property p_short_set;
		@(posedge aclk) disable iff (!aresetn)
		short_cause |=> line_short_fault_flag;
	endproperty
	a_short_set: assert property (p_short_set) else $error("short flag not set");

	property p_short_hold;
		@(posedge aclk) disable iff (!aresetn)
		(short_r && !clr_pulse) |=> short_r;
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short flag dropped");

	property p_clear_all;
		@(posedge aclk) disable iff (!aresetn)
		(s_clear_on_off ##0 (!short_cause && !line_voltage_drop_cond && !line_disconnect_cond
			&& !alarm_ev && !perr_ev && !any_ev)) |=> (!short_r && !vdrop_r && !disc_r
			&& !alarm_r && !perr_r && code_r == 16'h0000 && id_r == 10'h000
			&& nerr_r == '0 && nalm_r == '0);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear pulse left state");

	property p_summary;
		@(posedge aclk) disable iff (!aresetn)
		((short_cause || line_voltage_drop_cond || line_disconnect_cond) |=> error_status_flag)
			and (bridge_hw_fault |-> error_status_flag);
	endproperty
	a_summary: assert property (p_summary) else $error("summary flag missing");

	property p_alarm;
		@(posedge aclk) disable iff (!aresetn)
		ev_slave_status |=> slave_alarm_flag && code_r != 16'h0000;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm flag not set");

	property p_backup_code;
		@(posedge aclk) disable iff (!aresetn)
		ev_backup_bad |=> latest_error_code_word == 16'h01f4;
	endproperty
	a_backup_code: assert property (p_backup_code) else $error("backup code wrong");

	property p_unset;
		@(posedge aclk) disable iff (!aresetn)
		(ev_slave_addr_valid && ev_slave_addr == 8'hff && !ev_backup_bad && !ev_same_id)
			|=> latest_error_code_word == 16'h0191;
	endproperty
	a_unset: assert property (p_unset) else $error("unset id code wrong");

	property p_same_id;
		@(posedge aclk) disable iff (!aresetn)
		(ev_same_id && !ev_backup_bad) |=> latest_error_code_word == 16'h0190;
	endproperty
	a_same_id: assert property (p_same_id) else $error("same id code wrong");

	property p_hold_code;
		@(posedge aclk) disable iff (!aresetn)
		(!any_ev && !clr_pulse) |=> $stable(latest_error_code_word);
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code changed idle");
endmodule // ler_top

// ==== verif/ler_link_model.sv ====
// Link side model: slave fault pulses and line condition levels
`timescale 1ns/100ps
module ler_link_model (
	input  wire logic    aclk,
	output logic [8:0]   ev,
	output logic [4:0]   line,
	output logic [9:0]   par_id,
	output logic [9:0]   slave_id,
	output logic [7:0]   slave_addr,
	output logic [255:0] det_map
);
	// ****************************************
	// Idle values; only address 05 was found
	// ****************************************
	initial begin
		ev = 9'h000;
		line = 5'h00;
		par_id = 10'h000;
		slave_id = 10'h000;
		slave_addr = 8'h00;
		det_map = 256'h20;
	end

	// Input and combined slaves answer 200h above their address
	function automatic logic [9:0] make_id(input logic is_in, input logic [7:0] a);
		return is_in ? {2'b00, a} + ler_pkg::IN_ID_OFFSET : {2'b00, a};
	endfunction

	// One-cycle fault pulse; kind 9 and 10 are accesses that must stay quiet
	task automatic fire(input int k, input logic [9:0] sid);
		int b;
		b = (k == 9) ? 2 : (k == 10) ? 7 : k;
		@(posedge aclk);
		ev <= 9'h001 << b;
		slave_id <= sid;
		par_id <= make_id(1'b1, (k == 9) ? 8'h05 : 8'h06);
		slave_addr <= (k == 10) ? 8'h05 : ler_pkg::UNSET_ADDR;
		@(posedge aclk);
		// Hold time over: show the inverse, not a stale value
		ev <= 9'h000;
		slave_id <= ~sid;
		par_id <= ~par_id;
		slave_addr <= ~slave_addr;
	endtask

	// Line levels: short, overcurrent, drop, disconnect, bridge fault
	task automatic set_line(input logic [4:0] v);
		@(posedge aclk);
		line <= v;
	endtask
endmodule // ler_link_model

// ==== verif/ler_top_test.sv ====
// Self-checking bench of the link error reporting block
`timescale 1ns/100ps
module ler_top_test;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [8:0]  ev;
	logic [4:0]  line;
	logic [9:0]  par_id, slave_id;
	logic [7:0]  slave_addr;
	logic [255:0] det_map;
	logic [3:0]  wstrb = 4'hf;
	wire  [31:0] pins;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          bad_count = 0;
	int          n_compared = 0;
	localparam logic [31:0] F_SH = 32'h1 << ler_pkg::ST_SHORT;
	localparam logic [31:0] F_DR = 32'h1 << ler_pkg::ST_VDROP;
	localparam logic [31:0] F_DI = 32'h1 << ler_pkg::ST_DISC;
	localparam logic [31:0] F_AL = 32'h1 << ler_pkg::ST_ALARM;
	localparam logic [31:0] F_PE = 32'h1 << ler_pkg::ST_PERR;
	localparam logic [31:0] F_SU = 32'h1 << ler_pkg::ST_ERRSUM;
	localparam logic [31:0] F_CR = 32'h1 << ler_pkg::ST_CLR_REQ;
	localparam logic [15:0] CODES [9] = '{ler_pkg::ERR_SLV_HW_A, ler_pkg::ERR_SLV_HW_B,
		ler_pkg::ERR_PAR_ID, ler_pkg::ERR_PAR_VAL, ler_pkg::ERR_PAR_CORRUPT,
		ler_pkg::ERR_SLV_STAT, ler_pkg::ERR_SAME_ID, ler_pkg::ERR_NO_ID, ler_pkg::ERR_BACKUP};

	// 125 MHz clock
	always #4 aclk = ~aclk;

	ler_top #(.CNT_W(8)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ev_slave_hw(ev[0]), .ev_slave_hw_alt(ev[1]), .ev_par_access(ev[2]),
		.ev_par_id(par_id), .detected_map(det_map), .ev_par_range(ev[3]),
		.ev_par_corrupt(ev[4]), .ev_slave_status(ev[5]), .ev_same_id(ev[6]),
		.ev_slave_addr_valid(ev[7]), .ev_slave_addr(slave_addr), .ev_backup_bad(ev[8]),
		.ev_slave_id(slave_id), .line_short_cond(line[0]), .line_overcurrent_cond(line[1]),
		.line_voltage_drop_cond(line[2]), .line_disconnect_cond(line[3]),
		.bridge_hw_fault(line[4]), .line_short_fault_flag(pins[0]),
		.line_voltage_drop_flag(pins[1]), .line_disconnect_flag(pins[2]),
		.slave_alarm_flag(pins[3]), .param_error_flag(pins[4]), .error_status_flag(pins[5]),
		.latest_error_code_word(pins[31:16]), .latest_error_id_word(pins[15:6]));

	ler_link_model lm (.aclk(aclk), .ev(ev), .line(line), .par_id(par_id),
		.slave_id(slave_id), .slave_addr(slave_addr), .det_map(det_map));

	// ****************************************
	// Reporting
	// ****************************************
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t read got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_wr(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t bresp got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Pins as {code, id, summary, perr, alarm, disc, drop, short}
	task automatic cmp_pin(input logic [31:0] exp);
		n_compared++;
		if (pins !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t pins got=%h exp=%h", $time, pins, exp);
		end
	endtask

	// A wait that runs dry ends the run as a failure
	task automatic give_up(input int n);
		if (n >= 64) begin
			bad_count++;
			end_sim();
		end
	endtask

	// Watcher takes the oldest note whenever a response is handed over
	always @(posedge aclk) begin
		if (rvalid && rready && rq.size() > 0)
			cmp_rd({rresp, rdata}, rq.pop_front());
		if (bvalid && bready && bq.size() > 0)
			cmp_wr(bresp, bq.pop_front());
	end

	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = ler_pkg::RESP_OKAY);
		int n;
		bit aw, w;
		n = 0;
		aw = 0;
		w = 0;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
			give_up(n++);
		end
		while (!bvalid) begin
			@(posedge aclk);
			give_up(n++);
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = ler_pkg::RESP_OKAY);
		int n;
		n = 0;
		rq.push_back({e, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			give_up(n++);
		end while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) begin
			@(posedge aclk);
			give_up(n++);
		end
		rready <= 1'b0;
	endtask

	// On-then-off pulse of the clear request
	task automatic clr();
		wr(ler_pkg::REG_CTRL, 32'h1);
		wr(ler_pkg::REG_CTRL, 32'h0);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [9:0] sid;
		void'($urandom(92));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ler_pkg::REG_STATUS, 32'h0);
		rd(ler_pkg::REG_COUNTS, 32'h0);
		rd(8'h14, 32'h0, ler_pkg::RESP_SLVERR);
		wr(8'h14, 32'h1, ler_pkg::RESP_SLVERR);
		// Clear bit ignored when its byte lane is off
		wstrb <= 4'he;
		wr(ler_pkg::REG_CTRL, 32'h1);
		wstrb <= 4'hf;
		rd(ler_pkg::REG_CTRL, 32'h0);
		// Every coded fault once, with a random slave id
		for (int k = 0; k < 9; k++) begin
			sid = 10'($urandom);
			lm.fire(k, sid);
			rd(ler_pkg::REG_ERR_CODE, {16'h0, CODES[k]});
			rd(ler_pkg::REG_ERR_ID, {22'h0, sid});
		end
		// Detected id and a set address must not overwrite the code
		lm.fire(9, 10'h155);
		lm.fire(10, 10'h0aa);
		rd(ler_pkg::REG_ERR_CODE, {16'h0, ler_pkg::ERR_BACKUP});
		rd(ler_pkg::REG_COUNTS, 32'h0003_0009);
		rd(ler_pkg::REG_STATUS, F_AL | F_PE);
		cmp_pin({ler_pkg::ERR_BACKUP, sid, 6'h18});
		// Short, then overcurrent still present during the clear
		lm.set_line(5'h01);
		rd(ler_pkg::REG_STATUS, F_SH | F_AL | F_PE | F_SU);
		lm.set_line(5'h02);
		wr(ler_pkg::REG_CTRL, 32'h1);
		rd(ler_pkg::REG_CTRL, 32'h1);
		rd(ler_pkg::REG_STATUS, F_SH | F_AL | F_PE | F_SU | F_CR);
		wr(ler_pkg::REG_CTRL, 32'h0);
		rd(ler_pkg::REG_STATUS, F_SH | F_SU);
		rd(ler_pkg::REG_ERR_CODE, 32'h0);
		rd(ler_pkg::REG_ERR_ID, 32'h0);
		cmp_pin(32'h0000_0021);
		rd(ler_pkg::REG_COUNTS, 32'h0);
		lm.set_line(5'h00);
		rd(ler_pkg::REG_STATUS, F_SH | F_SU);
		clr();
		rd(ler_pkg::REG_STATUS, 32'h0);
		// Drop and disconnect stick; bridge fault only feeds the summary
		lm.set_line(5'h1c);
		lm.set_line(5'h00);
		rd(ler_pkg::REG_STATUS, F_DR | F_DI | F_SU);
		cmp_pin(32'h0000_0026);
		clr();
		lm.set_line(5'h10);
		rd(ler_pkg::REG_STATUS, F_SU);
		cmp_pin(32'h0000_0020);
		lm.set_line(5'h00);
		// Module reset in mid-run also clears everything
		lm.fire(8, 10'h2f0);
		lm.set_line(5'h01);
		lm.set_line(5'h00);
		@(posedge aclk);
		cmp_pin({ler_pkg::ERR_BACKUP, 10'h2f0, 6'h21});
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ler_pkg::REG_STATUS, 32'h0);
		rd(ler_pkg::REG_ERR_CODE, 32'h0);
		cmp_pin(32'h0000_0000);
		repeat (2) @(posedge aclk);
		end_sim();
	end
endmodule // ler_top_test
